//--- hw/pecc_fall_det.sv
// falling and rising edge detector on synchronised levels
`timescale 1ns/1ps
module pecc_fall_det (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    pecc_sync_if.dst        lvl_in,
    output logic      [7:0] fall_out,
    output logic      [7:0] rise_out
);
    logic [7:0] prev_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_r <= 8'hFF;
        end else begin
            prev_r <= lvl_in.lvl;
        end
    end

    assign fall_out = prev_r & ~lvl_in.lvl;
    assign rise_out = ~prev_r & lvl_in.lvl;
endmodule

//--- hw/pecc_pkg.sv
// constants and register layout for the power event and clock control block
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// ****************************************************************
package pecc_pkg;
    localparam logic [3:0]  STATUS_OFS       = 4'h0;
    localparam logic [3:0]  CLKCTL_OFS       = 4'h8;
    localparam int          STATUS_W         = 27;
    localparam int          CLKCTL_W         = 16;
    localparam int          EVT_N            = 11;
    localparam int          SWRST_BIT        = 26;
    localparam int          IEN_LO           = 11;
    localparam int          IEN_N            = 5;
    localparam int          USB_EN_BIT       = 15;
    localparam int          LCD_EN_BIT       = 14;
    localparam int          LCD_SEL_BIT      = 13;
    localparam int          MUTE_CTRL_BIT    = 7;
    localparam int          IMM_UPD_BIT      = 6;
    localparam int          FREQ_W           = 6;
    localparam logic [15:0] CLKCTL_RST       = 16'h002F;
    localparam logic [15:0] CLKCTL_WMASK     = 16'hE0FF;
    // event flag positions
    localparam int          EV_POR           = 0;
    localparam int          EV_DEEP          = 1;
    localparam int          EV_USB_UNLOCK    = 2;
    localparam int          EV_CPU_UNLOCK    = 3;
    localparam int          EV_WAKE_KEY      = 4;
    localparam int          EV_RING          = 5;
    localparam int          EV_ALARM         = 6;
    localparam int          EV_PFAIL         = 7;
    localparam int          EV_WARM          = 8;
    localparam int          EV_WDT           = 9;
    localparam int          EV_SYNC          = 10;
    // software warm reset pulse length
    localparam int          SWRST_NS         = 100;
    localparam int          CLK_NS           = 10;
    localparam int          SWRST_CYC        = (SWRST_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- hw/pecc_sync.sv
// two flip-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module pecc_sync (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [7:0] async_in,
    pecc_sync_if.src        sync_out
);
    logic [7:0] meta_r;
    logic [7:0] stab_r;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    meta_r[g] <= 1'b1;
                    stab_r[g] <= 1'b1;
                end else begin
                    meta_r[g] <= async_in[g];
                    stab_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign sync_out.lvl = stab_r;
endmodule

//--- hw/pecc_sync_if.sv
// bundle of synchronised event levels passed to the top
`timescale 1ns/1ps
interface pecc_sync_if;
    logic [7:0] lvl;
    modport src (output lvl);
    modport dst (input  lvl);
endinterface

//--- hw/pecc_top.sv
// power event status and clock control register block
`timescale 1ns/1ps
module pecc_top (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        reg_sel_in,
    input  wire logic        reg_wr_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        sync_request_pin_in,
    input  wire logic        battery_ok_input_in,
    input  wire logic        ring_indicator_n_in,
    input  wire logic        wake_key_n_in,
    input  wire logic        alarm_in,
    input  wire logic        external_reset_pin_n_in,
    input  wire logic        wdt_reset_in,
    input  wire logic        cpu_pll_lock_in,
    input  wire logic        usb_pll_lock_in,
    input  wire logic        deep_sleep_entry_in,
    output logic      [5:0]  cpu_pll_freq_out,
    output logic             usb_clock_en_out,
    output logic             lcd_clock_en_out,
    output logic             lcd_clock_sel_out,
    output logic             cpu_clock_mute_out,
    output logic             sw_reset_out,
    output logic             irq_out
);
    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    pecc_sync_if sync_bus ();
    logic [7:0] fall_w;
    logic [7:0] rise_w;

    pecc_sync u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        // lowest slot is spare, tied to its idle level
        .async_in ({deep_sleep_entry_in, wdt_reset_in, alarm_in, usb_pll_lock_in,
                    cpu_pll_lock_in, sync_request_pin_in, battery_ok_input_in,
                    1'b1}),
        .sync_out (sync_bus)
    );

    pecc_fall_det u_edge (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .lvl_in   (sync_bus),
        .fall_out (fall_w),
        .rise_out (rise_w)
    );

    // ring, wake key and external reset get their own two-stage chain
    logic [2:0] aux_meta_r;
    logic [2:0] aux_stab_r;
    logic [2:0] aux_prev_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aux_meta_r <= 3'h7;
            aux_stab_r <= 3'h7;
            aux_prev_r <= 3'h7;
        end else begin
            aux_meta_r <= {external_reset_pin_n_in, wake_key_n_in, ring_indicator_n_in};
            aux_stab_r <= aux_meta_r;
            aux_prev_r <= aux_stab_r;
        end
    end
    logic [2:0] aux_fall_w;
    assign aux_fall_w = aux_prev_r & ~aux_stab_r;

    // ****************************************************************
    // register access decode
    // ****************************************************************
    logic wr_status_w;
    logic wr_clkctl_w;
    assign wr_status_w = reg_sel_in & reg_wr_in & (reg_addr_in == pecc_pkg::STATUS_OFS);
    assign wr_clkctl_w = reg_sel_in & reg_wr_in & (reg_addr_in == pecc_pkg::CLKCTL_OFS);

    // ****************************************************************
    // software warm reset pulse
    // ****************************************************************
    logic [3:0] swrst_cnt_r;
    logic       swrst_req_w;
    assign swrst_req_w = wr_status_w & reg_wdata_in[pecc_pkg::SWRST_BIT];
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            swrst_cnt_r <= 4'h0;
        end else if (swrst_req_w) begin
            swrst_cnt_r <= 4'(pecc_pkg::SWRST_CYC);
        end else if (swrst_cnt_r != 4'h0) begin
            swrst_cnt_r <= swrst_cnt_r - 4'h1;
        end
    end
    assign sw_reset_out = (swrst_cnt_r != 4'h0);

    // ****************************************************************
    // sticky event flags
    // ****************************************************************
    logic [10:0] evt_set_w;
    logic [10:0] evt_clr_w;
    logic [10:0] evt_r;
    logic [10:0] evt_nxt;
    logic        por_seen_r;
    logic        imm_write_w;

    assign evt_set_w[pecc_pkg::EV_POR]        = ~por_seen_r;
    assign evt_set_w[pecc_pkg::EV_DEEP]       = rise_w[7];
    assign evt_set_w[pecc_pkg::EV_USB_UNLOCK] = fall_w[4];
    assign evt_set_w[pecc_pkg::EV_CPU_UNLOCK] = fall_w[3] | imm_write_w;
    assign evt_set_w[pecc_pkg::EV_WAKE_KEY]   = aux_fall_w[1];
    assign evt_set_w[pecc_pkg::EV_RING]       = aux_fall_w[0];
    assign evt_set_w[pecc_pkg::EV_ALARM]      = rise_w[5];
    assign evt_set_w[pecc_pkg::EV_PFAIL]      = fall_w[1];
    assign evt_set_w[pecc_pkg::EV_WARM]       = aux_fall_w[2] | swrst_req_w | rise_w[6];
    assign evt_set_w[pecc_pkg::EV_WDT]        = rise_w[6];
    assign evt_set_w[pecc_pkg::EV_SYNC]       = rise_w[2];

    assign evt_clr_w = wr_status_w ? reg_wdata_in[10:0] : 11'h000;
    assign evt_nxt   = (evt_r & ~evt_clr_w) | evt_set_w;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_r      <= 11'h000;
            por_seen_r <= 1'b0;
        end else begin
            evt_r      <= evt_nxt;
            por_seen_r <= 1'b1;
        end
    end

    // ****************************************************************
    // interrupt enables and interrupt
    // ****************************************************************
    logic [4:0] ien_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ien_r <= 5'h00;
        end else if (wr_status_w) begin
            ien_r <= reg_wdata_in[15:11];
        end
    end

    // enable order high to low: sync, pfail, alarm, ring, on key
    logic [4:0] irq_src_w;
    assign irq_src_w = {evt_r[pecc_pkg::EV_SYNC], evt_r[pecc_pkg::EV_PFAIL], evt_r[pecc_pkg::EV_ALARM],
                        evt_r[pecc_pkg::EV_RING], evt_r[pecc_pkg::EV_WAKE_KEY]};
    logic irq_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_src_w & ien_r);
        end
    end
    assign irq_out = irq_r;

    // ****************************************************************
    // clock control
    // ****************************************************************
    logic [15:0] clkctl_r;
    logic [5:0]  freq_hold_r;
    logic        deep_entry_w;
    assign deep_entry_w = rise_w[7];
    assign imm_write_w  = wr_clkctl_w & clkctl_r[pecc_pkg::IMM_UPD_BIT];

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clkctl_r    <= pecc_pkg::CLKCTL_RST;
            freq_hold_r <= pecc_pkg::CLKCTL_RST[5:0];
        end else if (wr_clkctl_w) begin
            clkctl_r[15:6] <= reg_wdata_in[15:6] & pecc_pkg::CLKCTL_WMASK[15:6];
            if (clkctl_r[pecc_pkg::IMM_UPD_BIT]) begin
                clkctl_r[5:0]  <= reg_wdata_in[5:0];
                freq_hold_r    <= reg_wdata_in[5:0];
            end else begin
                freq_hold_r    <= reg_wdata_in[5:0];
            end
        end else if (deep_entry_w) begin
            clkctl_r[5:0] <= freq_hold_r;
        end
    end

    // codes outside 0x0C..0x1E and 0x25..0x3E are passed through untouched
    assign cpu_pll_freq_out  = clkctl_r[5:0];
    assign usb_clock_en_out  = clkctl_r[pecc_pkg::USB_EN_BIT];
    assign lcd_clock_en_out  = clkctl_r[pecc_pkg::LCD_EN_BIT];
    assign lcd_clock_sel_out = clkctl_r[pecc_pkg::LCD_SEL_BIT];

    // mute starts the cycle after an immediate write, before lock drops
    logic mute_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mute_r <= 1'b1;
        end else if (!por_seen_r) begin
            mute_r <= 1'b1;
        end else if (clkctl_r[pecc_pkg::MUTE_CTRL_BIT]) begin
            mute_r <= 1'b0;
        end else begin
            mute_r <= imm_write_w | ~sync_bus.lvl[3];
        end
    end
    assign cpu_clock_mute_out = mute_r;

    // ****************************************************************
    // read back
    // ****************************************************************
    logic [31:0] status_rd_w;
    assign status_rd_w = {16'h0000, ien_r, evt_r};
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_sel_in & ~reg_wr_in) begin
            case (reg_addr_in)
                pecc_pkg::STATUS_OFS: reg_rdata_out <= status_rd_w;
                pecc_pkg::CLKCTL_OFS: reg_rdata_out <= {16'h0000, clkctl_r};
                default:              reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule

//--- verif/pecc_checker.sv
// concurrent checks on the ports of the power event and clock control block
`timescale 1ns/1ps
module pecc_checker (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        reg_sel_in,
    input wire logic        reg_wr_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [5:0]  cpu_pll_freq_out,
    input wire logic        usb_clock_en_out,
    input wire logic        lcd_clock_en_out,
    input wire logic        lcd_clock_sel_out,
    input wire logic        cpu_clock_mute_out,
    input wire logic        sw_reset_out,
    input wire logic        irq_out
);
    // ****
    // shadows and checks
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic       imm_r;
    logic       mctl_r;
    logic [4:0] ien_r;
    wire        st_wr   = reg_sel_in && reg_wr_in && reg_addr_in == pecc_pkg::STATUS_OFS;
    wire        cc_wr   = reg_sel_in && reg_wr_in && reg_addr_in == pecc_pkg::CLKCTL_OFS;
    wire        rd_any  = reg_sel_in && !reg_wr_in;
    wire  [2:0] gate_w  = reg_wdata_in[15:13];
    wire  [5:0] code_w  = reg_wdata_in[5:0];
    // registers are hidden from the checker, so mode bits are tracked here
    wire        imm_nxt  = cc_wr ? reg_wdata_in[6] : imm_r;
    wire        mctl_nxt = cc_wr ? reg_wdata_in[7] : mctl_r;
    wire  [4:0] ien_nxt  = st_wr ? reg_wdata_in[15:11] : ien_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            imm_r  <= 1'b0;
            mctl_r <= 1'b0;
            ien_r  <= 5'h00;
        end else begin
            imm_r  <= imm_nxt;
            mctl_r <= mctl_nxt;
            ien_r  <= ien_nxt;
        end
    end
    sequence seq_pulse_body;
        sw_reset_out [*8];
    endsequence
    sequence seq_pulse_tail;
        sw_reset_out [*2] ##1 !sw_reset_out;
    endsequence
    AST_SWRST_GO: assert property (st_wr && reg_wdata_in[26] |=> sw_reset_out)
        else $error("software reset pulse did not start");
    AST_SWRST_LEN: assert property ($rose(sw_reset_out) |-> seq_pulse_body ##1 seq_pulse_tail)
        else $error("software reset pulse length wrong");
    AST_CLK_GATES: assert property (cc_wr |=> {usb_clock_en_out, lcd_clock_en_out, lcd_clock_sel_out} == $past(gate_w))
        else $error("clock gate outputs do not follow the write");
    AST_FREQ_NOW: assert property (cc_wr && imm_r |=> cpu_pll_freq_out == $past(code_w))
        else $error("immediate frequency write not applied");
    AST_FREQ_HELD: assert property (cc_wr && !imm_r |=> $stable(cpu_pll_freq_out))
        else $error("held frequency write reached the pll");
    AST_MUTE_IMM: assert property (cc_wr && imm_r && !mctl_r && !reg_wdata_in[7] |-> ##[1:3] cpu_clock_mute_out)
        else $error("immediate frequency write did not mute");
    AST_IRQ_OFF: assert property (ien_r == 5'h00 && $past(ien_r) == 5'h00 |-> !irq_out)
        else $error("interrupt raised with all enables clear");
    AST_CC_RSVD: assert property (rd_any && reg_addr_in == pecc_pkg::CLKCTL_OFS |=>
        reg_rdata_out[31:16] == 16'h0000 && reg_rdata_out[12:8] == 5'h00) else $error("clock control reserved bits set");
    AST_ST_RSVD: assert property (rd_any && reg_addr_in == pecc_pkg::STATUS_OFS |=> reg_rdata_out[31:16] == 16'h0000)
        else $error("status upper bits not zero");
endmodule

//--- verif/test_pecc_top.sv
// self-checking bench for the power event and clock control block
`timescale 1ns/1ps
module test_pecc_top;
    localparam int          POS [10] = '{10, 7, 6, 5, 4, 8, 9, 3, 2, 1};
    localparam logic [5:0]  CORN [4] = '{6'h0C, 6'h1E, 6'h25, 6'h3E};
    logic        clk_in   = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        sel      = 1'b0;
    logic        wr       = 1'b0;
    logic [3:0]  addr     = 4'h0;
    logic [31:0] wdata    = 32'h0;
    logic [9:0]  act      = 10'h000;
    logic        mctl     = 1'b0;
    logic [31:0] rdata;
    logic [5:0]  freq;
    logic        usb_en;
    logic        lcd_en;
    logic        lcd_sel;
    logic        mute;
    logic        swr;
    logic        irq;
    int          err_count = 0;
    int          checks    = 0;
    logic [31:0] v;
    logic [31:0] w;
    logic [9:0]  m;
    logic [10:0] c;
    logic [5:0]  cd;
    logic [5:0]  cur;
    int          n;
    always #5 clk_in = ~clk_in;
    pecc_top pecc_top_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_sel_in(sel), .reg_wr_in(wr), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .sync_request_pin_in(act[0]), .battery_ok_input_in(~act[1]),
        .ring_indicator_n_in(~act[3]), .wake_key_n_in(~act[4]), .alarm_in(act[2]), .external_reset_pin_n_in(~act[5]),
        .wdt_reset_in(act[6]), .cpu_pll_lock_in(~act[7]), .usb_pll_lock_in(~act[8]), .deep_sleep_entry_in(act[9]),
        .cpu_pll_freq_out(freq), .usb_clock_en_out(usb_en), .lcd_clock_en_out(lcd_en), .lcd_clock_sel_out(lcd_sel),
        .cpu_clock_mute_out(mute), .sw_reset_out(swr), .irq_out(irq));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        sel <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        sel <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        sel <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge clk_in);
        sel <= 1'b0;
        #1;
        d = rdata;
    endtask
    // pins are synchronised, so each event is held well past the sync depth
    task automatic fire(input logic [9:0] e);
        @(posedge clk_in);
        act <= e;
        cyc(6);
        if (e[7]) chk(32'(mute), mctl ? 32'h0 : 32'h1);
        @(posedge clk_in);
        act <= 10'h000;
        cyc(6);
    endtask
    function automatic logic [31:0] flags_of(input logic [9:0] e);
        logic [31:0] f;
        f = 32'h0;
        for (int i = 0; i < 10; i++) if (e[i]) f[POS[i]] = 1'b1;
        if (e[6]) f[8] = 1'b1;
        return f;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(17));
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        cyc(3);
        rreg(4'h0, v);
        chk(v, 32'h00000001);
        rreg(4'h8, v);
        chk(v, 32'h0000002F);
        chk({freq, usb_en, lcd_en, lcd_sel, mute, irq}, 32'h000005E0);
        wreg(4'h0, 32'h00000001);
        rreg(4'h0, v);
        chk(v, 32'h0);
        $display("reset test done");
        for (int r = 0; r < 14; r++) begin
            m = (r < 9) ? (10'h001 << r) : (10'($urandom) & 10'h1FF);
            fire(m);
            rreg(4'h0, v);
            chk(v, flags_of(m));
            c = 11'($urandom);
            wreg(4'h0, 32'(c));
            rreg(4'h0, v);
            chk(v, flags_of(m) & ~32'(c));
            wreg(4'h0, 32'h000007FF);
        end
        $display("event test done");
        for (int i = 0; i < 5; i++) begin
            fire(10'h001 << i);
            chk(32'(irq), 32'h0);
            wreg(4'h0, 32'h1 << (15 - i));
            cyc(2);
            chk(32'(irq), 32'h1);
            rreg(4'h0, v);
            chk(v, (32'h1 << (15 - i)) | (32'h1 << POS[i]));
            wreg(4'h0, (32'h1 << (15 - i)) | (32'h1 << POS[i]));
            cyc(2);
            chk(32'(irq), 32'h0);
            wreg(4'h0, 32'h0);
        end
        $display("interrupt test done");
        cur = 6'h2F;
        for (int r = 0; r < 3; r++) begin
            cd = r[0] ? 6'(6'h25 + $urandom % 26) : 6'(6'h0C + $urandom % 19);
            w = {16'h0, 3'($urandom), 5'h1F, 2'b00, cd};
            wreg(4'h8, w);
            rreg(4'h8, v);
            chk(v, {16'h0, w[15:13], 7'h00, cur});
            chk({usb_en, lcd_en, lcd_sel, freq}, {w[15:13], cur});
            fire(10'h200);
            cur = cd;
            rreg(4'h8, v);
            chk(v, {16'h0, w[15:13], 7'h00, cur});
            rreg(4'h0, v);
            chk(v, 32'h00000002);
            wreg(4'h0, 32'h000007FF);
        end
        wreg(4'h8, 32'h00000040 | 32'(cur));
        for (int r = 0; r < 8; r++) begin
            cd = (r < 4) ? CORN[r] : (r[0] ? 6'(6'h25 + $urandom % 26) : 6'(6'h0C + $urandom % 19));
            wreg(4'h8, {24'h0, 2'b01, cd});
            chk(32'(freq), 32'(cd));
            // mute stands one cycle here, as the bench keeps the pll locked
            chk(32'(mute), 32'h1);
            cyc(7);
        end
        rreg(4'h0, v);
        chk(v & 32'h8, 32'h8);
        wreg(4'h8, 32'h00000080 | 32'(cd));
        cyc(8);
        mctl = 1'b1;
        fire(10'h080);
        wreg(4'h0, 32'h000007FF);
        $display("clock control test done");
        // clearing the warm flag in the same write that sets it: set must win
        wreg(4'h0, 32'h04000100);
        n = 0;
        repeat (20) begin
            if (swr === 1'b1) n++;
            cyc(1);
        end
        chk(n, 32'd10);
        rreg(4'h0, v);
        chk(v, 32'h00000100);
        wreg(4'h0, 32'h000007FF);
        wreg(4'h4, 32'hFFFFFFFF);
        rreg(4'h4, v);
        chk(v, 32'h0);
        rreg(4'h0, v);
        chk(v, 32'h0);
        $display("software reset test done");
        tally_and_finish();
    end
endmodule
bind pecc_top pecc_checker pecc_checker_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_sel_in(reg_sel_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .cpu_pll_freq_out(cpu_pll_freq_out), .usb_clock_en_out(usb_clock_en_out), .lcd_clock_en_out(lcd_clock_en_out),
    .lcd_clock_sel_out(lcd_clock_sel_out), .cpu_clock_mute_out(cpu_clock_mute_out), .sw_reset_out(sw_reset_out),
    .irq_out(irq_out));
